// >>> verilog/cfr_pkg.sv
`default_nettype none
// shared constants for the condition flags register block
package cfr_pkg;
  // flag bit positions inside the 8-bit register
  localparam int unsigned FLAG_W   = 8;
  localparam int unsigned BIT_OVF  = 7;   // two's complement overflow
  localparam int unsigned BIT_ONE6 = 6;   // hard-wired one
  localparam int unsigned BIT_ONE5 = 5;   // hard-wired one
  localparam int unsigned BIT_HALF = 4;   // half-carry
  localparam int unsigned BIT_MASK = 3;   // global interrupt mask
  localparam int unsigned BIT_NEG  = 2;   // negative
  localparam int unsigned BIT_ZERO = 1;   // zero
  localparam int unsigned BIT_CARR = 0;   // carry
  // bits that always read as one
  localparam logic [7:0] ONES_MASK = 8'h60;
  // the five result flags
  localparam logic [7:0] RES_MASK  = 8'h97;
  // mask bit value after reset
  localparam logic       MASK_RST  = 1'h1;
  // register offsets on the plain register port
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0] OFS_FLAGS  = 4'h0;  // condition_flags
  localparam logic [3:0] OFS_STATUS = 4'h1;  // known flags and live mask
  // status register layout
  localparam int unsigned ST_EFF   = 7;     // effective mask seen by recognition
  localparam int unsigned ST_PEND  = 6;     // boundary update waiting
  // branch condition codes
  typedef enum logic [4:0] {
    BR_ALWAYS = 5'h00, BR_NEVER = 5'h01,
    BR_HI     = 5'h02, BR_LS    = 5'h03,
    BR_CC     = 5'h04, BR_CS    = 5'h05,
    BR_NE     = 5'h06, BR_EQ    = 5'h07,
    BR_HCC    = 5'h08, BR_HCS   = 5'h09,
    BR_PL     = 5'h0A, BR_MI    = 5'h0B,
    BR_MC     = 5'h0C, BR_MS    = 5'h0D,
    BR_LT     = 5'h0E, BR_GE    = 5'h0F,
    BR_GT     = 5'h10, BR_LE    = 5'h11
  } cfr_branch_t;
endpackage : cfr_pkg
`default_nettype wire

// >>> verilog/cfr_branch_eval.sv
`default_nettype none
// combinational branch decision from the current flag byte
module cfr_branch_eval (
  input  wire logic [7:0] flags_i,   // current flag byte
  input  wire logic [4:0] cond_i,    // branch condition code
  output logic            taken_o    // branch decision
);
  logic v, h, i, n, z, c;            // unpacked flags

  always_comb begin
    v = flags_i[cfr_pkg::BIT_OVF];
    h = flags_i[cfr_pkg::BIT_HALF];
    i = flags_i[cfr_pkg::BIT_MASK];
    n = flags_i[cfr_pkg::BIT_NEG];
    z = flags_i[cfr_pkg::BIT_ZERO];
    c = flags_i[cfr_pkg::BIT_CARR];
    case (cfr_pkg::cfr_branch_t'(cond_i))
      cfr_pkg::BR_ALWAYS: taken_o = 1'b1;
      cfr_pkg::BR_NEVER:  taken_o = 1'b0;
      // unsigned compares use carry as the overflow indicator
      cfr_pkg::BR_HI:     taken_o = ~(c | z);        // [RL4] [RL6]
      cfr_pkg::BR_LS:     taken_o = c | z;           // [RL4] [RL6]
      cfr_pkg::BR_CC:     taken_o = ~c;              // [RL4]
      cfr_pkg::BR_CS:     taken_o = c;               // [RL4]
      cfr_pkg::BR_NE:     taken_o = ~z;              // [RL4]
      cfr_pkg::BR_EQ:     taken_o = z;               // [RL4]
      cfr_pkg::BR_HCC:    taken_o = ~h;              // [RL4]
      cfr_pkg::BR_HCS:    taken_o = h;               // [RL4]
      cfr_pkg::BR_PL:     taken_o = ~n;              // [RL4]
      cfr_pkg::BR_MI:     taken_o = n;               // [RL4]
      cfr_pkg::BR_MC:     taken_o = ~i;              // [RL4]
      cfr_pkg::BR_MS:     taken_o = i;               // [RL4]
      // signed compares use the two's complement overflow
      cfr_pkg::BR_LT:     taken_o = n ^ v;           // [RL4] [RL6]
      cfr_pkg::BR_GE:     taken_o = ~(n ^ v);        // [RL4] [RL6]
      cfr_pkg::BR_GT:     taken_o = ~(z | (n ^ v));  // [RL4] [RL6]
      cfr_pkg::BR_LE:     taken_o = z | (n ^ v);     // [RL5] [RL6]
      default:            taken_o = 1'b0;            // unused codes never branch
    endcase
  end
endmodule // cfr_branch_eval
`default_nettype wire

// >>> verilog/cfr_top.sv
`default_nettype none
// Overview of operation
// [RL1] eight bits, bits six and five read one
// [RL2] reset forces the interrupt mask to one
// [RL3] result flags undefined until first update
// [RL4] simple branches one flag, compound two-three
// [RL5] less-or-equal: zero, or negative differs overflow
// [RL6] signed uses overflow, unsigned uses carry
// [RL7] mask one blocks every maskable request
// [RL8] set-mask writes one, clear-mask writes zero
// [RL9] accepting any interrupt sets the mask
// [RL10] flags stacked before mask set on entry
// [RL11] return reloads flags in first cycle
// [RL12] wait and stop clear mask mid-instruction
// [RL13] mask set lands at closing boundary
// [RL14] mask clear lets one more instruction run
// [RL15] accumulator transfer loads every implemented bit
// [RL16] fixed flag bit positions
module cfr_top #(
  parameter int unsigned ADDR_W = cfr_pkg::ADDR_W   // register port address width
) (
  input  wire logic              clock_i,        // cpu clock, 40 MHz
  input  wire logic              rstn_i,         // async reset, active low
  // sequencer strobes, one cycle each
  input  wire logic              boundary_i,     // instruction boundary
  input  wire logic              set_mask_i,     // set-mask instruction
  input  wire logic              clear_mask_i,   // clear-mask instruction
  input  wire logic              tap_i,          // accumulator to flags
  input  wire logic [7:0]        acc_i,          // accumulator value
  input  wire logic              alu_we_i,       // alu result flag write
  input  wire logic [7:0]        alu_sel_i,      // which result flags to write
  input  wire logic [7:0]        alu_flags_i,    // alu flag values
  input  wire logic              int_accept_i,   // interrupt entry, incl. software
  input  wire logic              rti_i,          // return, first cycle
  input  wire logic [7:0]        stack_i,        // flag byte pulled from stack
  input  wire logic              wait_stop_i,    // wait/stop mid-point
  input  wire logic              irq_req_i,      // maskable request pending
  input  wire logic              br_eval_i,      // evaluate branch
  input  wire logic [4:0]        br_cond_i,      // branch condition code
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,         // register address
  input  wire logic [7:0]        wdata_i,        // write data
  input  wire logic              we_i,           // write strobe
  input  wire logic              re_i,           // read strobe
  output logic      [7:0]        rdata_o,        // read data, one cycle later
  // status toward the cpu
  output logic      [7:0]        flags_o,        // live flag byte
  output logic      [7:0]        stacked_o,      // byte to push on entry
  output logic                   stack_we_o,     // stack write pulse
  output logic                   irq_take_o,     // interrupt recognised pulse
  output logic                   br_taken_o,     // branch decision
  output logic                   br_valid_o      // branch decision pulse
);
  // elaboration-time refusal of address widths the decoder cannot serve
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("cfr_top: ADDR_W out of range");
  end

  logic [7:0] res_r;       // result flags, no reset
  logic [7:0] known_r;     // which result flags hold a defined value
  logic       mask_r;      // architectural mask bit
  logic       eff_r;       // mask as seen by recognition
  logic       pend_r;      // boundary-timed mask update waiting
  logic       pend_val_r;  // value it will write
  logic       lag_r;       // one-cycle lag for mid-instruction clears
  logic [7:0] flags_nxt;   // assembled flag byte
  logic       br_nxt;      // evaluator output
  logic       bus_wr_f;    // software write to the flag register
  logic       take_nxt;    // recognition this cycle

  // bus writes to the flag register act like an accumulator transfer
  assign bus_wr_f = we_i && (addr_i == ADDR_W'(cfr_pkg::OFS_FLAGS));

  // assemble the byte; bits six and five are forced high
  always_comb begin
    flags_nxt = res_r & cfr_pkg::RES_MASK;              // [RL16]
    flags_nxt[cfr_pkg::BIT_MASK] = mask_r;               // [RL16]
    flags_nxt = flags_nxt | cfr_pkg::ONES_MASK;          // [RL1]
  end

  // result flags carry no reset: their power-up value is unknown by design
  always_ff @(posedge clock_i) begin
    if (rti_i) begin
      res_r <= stack_i & cfr_pkg::RES_MASK;              // [RL11]
    end else if (tap_i) begin
      res_r <= acc_i & cfr_pkg::RES_MASK;                // [RL15]
    end else if (bus_wr_f) begin
      res_r <= wdata_i & cfr_pkg::RES_MASK;              // [RL15]
    end else if (alu_we_i) begin
      res_r <= (res_r & ~alu_sel_i) | (alu_flags_i & alu_sel_i);
    end
  end

  // tracks which result flags have been written since reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      known_r <= 8'h00;                                  // [RL3]
    end else if (rti_i || tap_i || bus_wr_f) begin
      known_r <= cfr_pkg::RES_MASK;                      // [RL3]
    end else if (alu_we_i) begin
      known_r <= known_r | (alu_sel_i & cfr_pkg::RES_MASK); // [RL3]
    end
  end

  // pending boundary-timed mask update from set/clear/transfer
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_r     <= 1'b0;
      pend_val_r <= 1'b0;
    end else if (int_accept_i || rti_i || wait_stop_i) begin
      // a direct mask write overrides anything queued
      pend_r     <= 1'b0;
    end else if (set_mask_i) begin
      pend_r     <= 1'b1;                                // [RL8] [RL13]
      pend_val_r <= 1'b1;
    end else if (clear_mask_i) begin
      pend_r     <= 1'b1;                                // [RL8] [RL14]
      pend_val_r <= 1'b0;
    end else if (tap_i) begin
      pend_r     <= 1'b1;                                // [RL15] [RL13]
      pend_val_r <= acc_i[cfr_pkg::BIT_MASK];
    end else if (bus_wr_f) begin
      pend_r     <= 1'b1;
      pend_val_r <= wdata_i[cfr_pkg::BIT_MASK];
    end else if (boundary_i) begin
      pend_r     <= 1'b0;
    end
  end

  // architectural mask bit; entry wins over every clear in the same cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_r <= cfr_pkg::MASK_RST;                       // [RL2]
    end else if (int_accept_i) begin
      mask_r <= 1'b1;                                    // [RL9]
    end else if (rti_i) begin
      mask_r <= stack_i[cfr_pkg::BIT_MASK];              // [RL11]
    end else if (wait_stop_i) begin
      mask_r <= 1'b0;                                    // [RL12]
    end else if (boundary_i && pend_r) begin
      mask_r <= pend_val_r;                              // [RL13] [RL14]
    end
  end

  // mid-instruction clears reach recognition one cycle late
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lag_r <= 1'b0;
    end else if (int_accept_i) begin
      lag_r <= 1'b0;
    end else begin
      lag_r <= (rti_i && !stack_i[cfr_pkg::BIT_MASK]) || wait_stop_i; // [RL11] [RL12]
    end
  end

  // effective mask: a clear at a boundary still blocks that boundary,
  // so the next instruction always runs before a waiting request
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eff_r <= cfr_pkg::MASK_RST;                        // [RL2]
    end else if (int_accept_i) begin
      eff_r <= 1'b1;                                     // [RL9]
    end else if (rti_i && stack_i[cfr_pkg::BIT_MASK]) begin
      eff_r <= 1'b1;                                     // [RL11]
    end else if (lag_r) begin
      eff_r <= 1'b0;                                     // [RL11] [RL12]
    end else if (boundary_i && pend_r) begin
      eff_r <= pend_val_r;                               // [RL13] [RL14]
    end
  end

  // recognition uses the mask in force before this boundary's update,
  // which lets a request slip in right after a set-mask
  assign take_nxt = boundary_i && irq_req_i && !eff_r;   // [RL7] [RL13]

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_take_o <= 1'b0;
    end else begin
      irq_take_o <= take_nxt;                            // [RL7]
    end
  end

  // stacked copy is captured before the mask goes high
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stacked_o  <= cfr_pkg::ONES_MASK;
      stack_we_o <= 1'b0;
    end else begin
      stack_we_o <= int_accept_i;
      if (int_accept_i) begin
        stacked_o <= flags_nxt;                          // [RL10]
      end
    end
  end

  // live flag byte, registered
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_o <= cfr_pkg::ONES_MASK | 8'h08;             // [RL1] [RL2]
    end else begin
      flags_o <= flags_nxt;                              // [RL1]
    end
  end

  cfr_branch_eval u_branch (
    .flags_i (flags_nxt),
    .cond_i  (br_cond_i),
    .taken_o (br_nxt)
  );

  // branch decision from the flags current in the request cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      br_taken_o <= 1'b0;
      br_valid_o <= 1'b0;
    end else begin
      br_valid_o <= br_eval_i;
      if (br_eval_i) begin
        br_taken_o <= br_nxt;                            // [RL4] [RL5]
      end
    end
  end

  // register read port; unmapped addresses read zero
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (re_i) begin
      if (addr_i == ADDR_W'(cfr_pkg::OFS_FLAGS)) begin
        rdata_o <= flags_nxt;                            // [RL1]
      end else if (addr_i == ADDR_W'(cfr_pkg::OFS_STATUS)) begin
        rdata_o <= known_r;
        rdata_o[cfr_pkg::ST_EFF]  <= eff_r;
        rdata_o[cfr_pkg::ST_PEND] <= pend_r;
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // cfr_top
`default_nettype wire

// >>> testbench/cfr_irq_src.sv
`default_nettype none
// request source: a peripheral keeps asking until the cpu services it
module cfr_irq_src (
  input  wire logic clock_i,   // cpu clock
  input  wire logic rstn_i,    // async reset, active low
  input  wire logic raise_i,   // new request event
  input  wire logic take_i,    // recognised pulse from the block
  output logic      irq_req_o  // level request toward the block
);
  // held through masked boundaries, so a blocked request is not lost
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_req_o <= 1'b0;
    end else if (take_i) begin // serviced: drop the line
      irq_req_o <= 1'b0;
    end else if (raise_i) begin
      irq_req_o <= 1'b1;
    end
  end
endmodule // cfr_irq_src
`default_nettype wire

// >>> testbench/cfr_top_asserts.sv
`default_nettype none
// port-level checks on the flag register
module cfr_top_chk #(
  parameter int unsigned ADDR_W = 4    // register port address width
) (
  input wire logic       clock_i,      // cpu clock
  input wire logic       rstn_i,       // async reset, active low
  input wire logic       boundary_i,   // instruction boundary
  input wire logic       int_accept_i, // interrupt entry
  input wire logic       rti_i,        // return, first cycle
  input wire logic       wait_stop_i,  // wait/stop mid-point
  input wire logic [7:0] stack_i,      // pulled flag byte
  input wire logic       re_i,         // read strobe
  input wire logic       br_eval_i,    // branch evaluate
  input wire logic [4:0] br_cond_i,    // branch code
  input wire logic [7:0] rdata_o,      // read data
  input wire logic [7:0] flags_o,      // live flags
  input wire logic [7:0] stacked_o,    // byte pushed on entry
  input wire logic       stack_we_o,   // push pulse
  input wire logic       irq_take_o,   // recognised pulse
  input wire logic       br_taken_o,   // branch decision
  input wire logic       br_valid_o    // decision pulse
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  a_ones_fixed: assert property (flags_o[6:5] == 2'b11)
    else $error("fixed bits not one");
  // recognition only at a boundary with the mask clear beforehand
  a_take_unmasked: assert property (irq_take_o |-> $past(boundary_i) && !$past(flags_o[3]))
    else $error("request taken while masked");
  a_entry_sets: assert property (int_accept_i |=> stack_we_o ##1 flags_o[3])
    else $error("entry left mask clear");
  a_stack_old: assert property (int_accept_i |=> stacked_o == flags_o)
    else $error("stacked byte not pre-entry flags");
  a_rti_reload: assert property (rti_i && !int_accept_i |-> ##2 flags_o == ($past(stack_i, 2) | 8'h60))
    else $error("return did not reload flags");
  a_wait_clear: assert property (wait_stop_i && !int_accept_i && !rti_i |-> ##2 !flags_o[3])
    else $error("wait/stop left mask set");
  a_rdata_idle: assert property (!re_i |=> rdata_o == 8'h00)
    else $error("read data outside slot");
  a_branch_le: assert property (br_eval_i && br_cond_i == cfr_pkg::BR_LE |=> br_valid_o
    && br_taken_o == (flags_o[1] | (flags_o[2] ^ flags_o[7])))
    else $error("less-or-equal decision wrong");
  c_take: cover property (irq_take_o);
  c_push: cover property (stack_we_o);
  c_branch: cover property (br_valid_o && br_taken_o);
endmodule // cfr_top_chk
bind cfr_top cfr_top_chk #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// >>> testbench/test_cfr_top.sv
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
// sequence-level bench: sequencer strobes and register port calls
module test_cfr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rstn_i, boundary_i, set_mask_i, clear_mask_i, tap_i, alu_we_i, int_accept_i;
  logic rti_i, wait_stop_i, irq_req_i, br_eval_i, we_i, re_i, stack_we_o, irq_take_o;
  logic br_taken_o, br_valid_o, raise;
  logic [7:0] acc_i, alu_sel_i, alu_flags_i, stack_i, wdata_i, rdata_o, flags_o, stacked_o, prev;
  logic [4:0] br_cond_i;
  logic [3:0] addr_i;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] vals[3] = '{8'h00, 8'h9F, 8'h82};
  logic [7:0] fv[6] = '{8'h00, 8'h97, 8'h82, 8'h84, 8'h11, 8'h0D};
  cfr_top dut_u (.*);
  cfr_irq_src src_u (.clock_i(clock_i), .rstn_i(rstn_i), .raise_i(raise), .take_i(irq_take_o),
                     .irq_req_o(irq_req_i));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  // branch reference: odd codes hold the base test, even codes its inverse
  function automatic logic br_ref(input logic [7:0] f, input logic [4:0] c);
    logic [8:0] b;
    b = {f[1] | (f[2] ^ f[7]), ~(f[2] ^ f[7]), f[3], f[2], f[4], f[1], f[0], f[0] | f[1], 1'b0};
    if (c > 5'h11) return 1'b0;
    return c[0] ? b[c[4:1]] : ~b[c[4:1]];
  endfunction
  task automatic cyc(); @(posedge clock_i); endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a; wdata_i <= d; we_i <= 1'b1; cyc(); we_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    addr_i <= a; re_i <= 1'b1; cyc(); re_i <= 1'b0; #1 `CHK(rdata_o & m, e) cyc();
  endtask
  task automatic bnd(); boundary_i <= 1'b1; cyc(); boundary_i <= 1'b0; #1; endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) cyc();
    n_errors++;
    final_report();
  end
  initial begin
    {rstn_i, boundary_i, set_mask_i, clear_mask_i, tap_i, alu_we_i, int_accept_i, rti_i} = '0;
    {wait_stop_i, br_eval_i, we_i, re_i, raise, acc_i, alu_sel_i, alu_flags_i} = '0;
    {stack_i, wdata_i, br_cond_i, addr_i} = '0;
    repeat (20) cyc();
    rstn_i <= 1'b1;
    cyc();
    #1 `CHK({flags_o[6:5], flags_o[3]}, 3'h7)
    cyc(); rd(4'h1, 8'h17, 8'h00);
    alu_we_i <= 1'b1; alu_sel_i <= 8'h97; cyc(); alu_we_i <= 1'b0; cyc();
    #1 `CHK(flags_o, 8'h68)
    cyc(); rd(4'h1, 8'h17, 8'h17);
    $display("reset test done");
    prev = 8'h68;
    foreach (vals[i]) begin
      wr(4'h0, vals[i]); cyc();
      #1 `CHK(flags_o, (vals[i] & 8'h97) | 8'h60 | (prev & 8'h08))
      cyc(); bnd(); cyc(); #1 `CHK(flags_o, vals[i] | 8'h60)
      cyc(); rd(4'h0, 8'hFF, vals[i] | 8'h60);
      prev = vals[i] | 8'h60;
    end
    wr(4'hF, 8'h00); rd(4'hF, 8'hFF, 8'h00); rd(4'h0, 8'hFF, prev);
    $display("register test done");
    foreach (fv[i]) begin
      acc_i <= fv[i]; tap_i <= 1'b1; cyc(); tap_i <= 1'b0; bnd(); cyc();
      for (int c = 0; c < 19; c++) begin
        br_eval_i <= 1'b1; br_cond_i <= c[4:0]; cyc(); br_eval_i <= 1'b0;
        #1 `CHK({br_valid_o, br_taken_o}, {1'b1, br_ref(fv[i] | 8'h60, c[4:0])})
        cyc();
      end
    end
    $display("branch test done");
    raise <= 1'b1; cyc(); raise <= 1'b0; bnd(); `CHK(irq_take_o, 1'b0)
    cyc(); clear_mask_i <= 1'b1; cyc(); clear_mask_i <= 1'b0; bnd(); `CHK(irq_take_o, 1'b0)
    cyc(); #1 `CHK(flags_o[3], 1'b0)
    cyc(); bnd(); `CHK(irq_take_o, 1'b1)
    cyc(); int_accept_i <= 1'b1; cyc(); int_accept_i <= 1'b0;
    #1 `CHK({stack_we_o, stacked_o}, {1'b1, 8'h65})
    cyc(); #1 `CHK(flags_o[3], 1'b1)
    cyc(); rti_i <= 1'b1; stack_i <= 8'h84; cyc(); rti_i <= 1'b0;
    cyc(); #1 `CHK(flags_o, 8'hE4)
    cyc(); raise <= 1'b1; cyc(); raise <= 1'b0; bnd(); `CHK(irq_take_o, 1'b1)
    cyc(); raise <= 1'b1; set_mask_i <= 1'b1; cyc(); raise <= 1'b0; set_mask_i <= 1'b0;
    #1 `CHK(flags_o[3], 1'b0)
    cyc(); bnd(); `CHK(irq_take_o, 1'b1)
    cyc(); #1 `CHK(flags_o[3], 1'b1)
    cyc(); wait_stop_i <= 1'b1; cyc(); wait_stop_i <= 1'b0;
    cyc(); #1 `CHK(flags_o[3], 1'b0)
    cyc(); raise <= 1'b1; cyc(); raise <= 1'b0; bnd(); `CHK(irq_take_o, 1'b1)
    $display("mask test done");
    final_report();
  end
endmodule // test_cfr_top
`default_nettype wire
